// file: hw/mmu_fault_unit.sv
// address translation, protection and fault reporting for the processor core
// assumes first- and second-level entries arrive with the request, already fetched
// assumes a classic wishbone master on the register port, same clock
`timescale 1ns/100ps
module mmu_fault_unit (
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// translation request from the core
	input wire logic req_valid,
	input wire logic [31:0] req_addr,
	input wire logic req_write,
	input wire logic req_word,
	input wire logic req_user,
	input wire logic req_data,
	input wire logic [31:0] first_entry,
	input wire logic [31:0] second_entry,
	// answer to the core and memory side
	output logic resp_valid,
	output logic resp_abort,
	output logic resp_data_abort,
	output logic [31:0] phys_addr,
	output logic mem_start,
	output logic mem_write,
	output logic mem_bufferable,
	output logic mem_cacheable
);

	// software visible state
	localparam int CTL_W = mmu_fault_pkg::CTL_WIDTH;
	logic [31:0] domain_permission_map;
	logic [CTL_W-1:0] control;
	logic [3:0] fault_source_code;
	logic [3:0] fault_domain;
	logic [31:0] fault_address_reg;

	// decoded control bits
	// enables are plain register bits, no interlock on illegal mixes
	logic mmu_en;
	logic align_en;
	logic cache_en;
	logic wbuf_en;
	logic sys_s;
	logic rom_r;

	// second-level decode results
	logic page_invalid;
	logic page_large;
	logic page_bufferable;
	logic page_cacheable;
	logic [1:0] page_ap;
	logic [31:0] page_phys;

	// combinational verdict for the current request
	// all of these settle within the cycle the request stands
	logic next_fault;
	logic [3:0] next_code;
	logic [3:0] next_domain;
	logic [31:0] next_phys;
	logic next_bufferable;
	logic next_cacheable;

	// first-level view
	// only the type bits, domain and section permission matter here
	logic [1:0] first_type;
	logic [3:0] entry_domain;
	logic [1:0] domain_access;
	logic [1:0] section_ap;
	logic misaligned;

	// bus decode
	logic bus_req;
	logic bus_write;
	logic [31:0] read_mux;

	assign mmu_en = control[mmu_fault_pkg::CTL_MMU_EN];
	assign align_en = control[mmu_fault_pkg::CTL_ALIGN_EN];
	assign cache_en = control[mmu_fault_pkg::CTL_CACHE_EN];
	assign wbuf_en = control[mmu_fault_pkg::CTL_WBUF_EN];
	assign sys_s = control[mmu_fault_pkg::CTL_SYS_S];
	assign rom_r = control[mmu_fault_pkg::CTL_ROM_R];

	// permission table shared by sections and subpages
	// ap 00 leans on the control s and r bits, the rest stand alone
	function automatic logic perm_ok(
		input logic [1:0] ap,
		input logic s_bit,
		input logic r_bit,
		input logic user,
		input logic write
	);
		logic ok;
		ok = 1'b0;
		unique case (ap)
			mmu_fault_pkg::AP_SYSTEM: begin
				// s and r both set is reserved and treated as no access
				if (s_bit && !r_bit) begin
					ok = !user && !write;
				end else if (!s_bit && r_bit) begin
					ok = !write;
				end else begin
					ok = 1'b0;
				end
			end
			mmu_fault_pkg::AP_SUPER_ONLY: ok = !user;
			mmu_fault_pkg::AP_USER_READ: ok = !user || !write;
			mmu_fault_pkg::AP_ALL: ok = 1'b1;
		endcase
		return ok;
	endfunction : perm_ok

	// second-level entry decode
	// runs beside the first-level checks; its results only count
	// when the first-level entry points at a page table
	page_entry_decode entry_decode (
		.entry(second_entry),
		.virt_addr(req_addr),
		.entry_invalid(page_invalid),
		.is_large(page_large),
		.bufferable(page_bufferable),
		.cacheable(page_cacheable),
		.subpage_ap(page_ap),
		.phys_addr(page_phys)
	);

	// first-level fields and the governing domain
	// the domain index comes from the first level, pages included
	assign first_type = first_entry[1:0];
	assign entry_domain = first_entry[mmu_fault_pkg::DESC_DOMAIN_LSB +: 4];
	assign domain_access = domain_permission_map[{entry_domain, 1'b0} +: 2];
	assign section_ap = first_entry[mmu_fault_pkg::DESC_SECTION_AP_LSB +: 2];

	// only data word accesses can be misaligned, never prefetches
	// judged even with translation off, its enable is separate
	assign misaligned = align_en && req_data && req_word && (req_addr[1:0] != 2'h0);

	// fault evaluation, earlier branches carry higher priority
	// order: alignment, section translation, page translation,
	// section domain, page domain, section and page permission
	// only the winner is reported, masked faults show up on retry
	// manager domains fall through the permission branches
	always_comb begin
		next_fault = 1'b0;
		next_code = mmu_fault_pkg::FS_NONE;
		next_domain = entry_domain;
		next_phys = req_addr;
		next_bufferable = 1'b0;
		next_cacheable = 1'b0;
		// alignment first, with or without translation
		if (misaligned) begin
			// domain is don't care here, report zero
			next_fault = 1'b1;
			next_code = mmu_fault_pkg::FS_ALIGNMENT;
			next_domain = 4'h0;
		end else if (!mmu_en) begin
			// flat translation, no attributes
			// cache and buffer stay off while translation is off
			next_phys = req_addr;
		end else if (first_type == mmu_fault_pkg::TYPE_INVALID ||
			first_type == mmu_fault_pkg::TYPE_RESERVED) begin
			next_fault = 1'b1;
			next_code = mmu_fault_pkg::FS_SECTION_TRANSLATION;
			next_domain = entry_domain;
		end else if (first_type == mmu_fault_pkg::TYPE_SECTION_OR_SMALL) begin
			// section mapped access
			// sections carry one permission field, no subpage split
			if (domain_access == mmu_fault_pkg::DOM_NO_ACCESS ||
				domain_access == mmu_fault_pkg::DOM_RESERVED) begin
				next_fault = 1'b1;
				next_code = mmu_fault_pkg::FS_SECTION_DOMAIN;
			end else if (domain_access == mmu_fault_pkg::DOM_CLIENT &&
				!perm_ok(section_ap, sys_s, rom_r, req_user, req_write)) begin
				next_fault = 1'b1;
				next_code = mmu_fault_pkg::FS_SECTION_PERMISSION;
			end else begin
				next_phys = {first_entry[31:mmu_fault_pkg::SECTION_PAGE_LSB],
					req_addr[mmu_fault_pkg::SECTION_PAGE_LSB-1:0]};
				next_bufferable = first_entry[mmu_fault_pkg::DESC_BUFFERABLE];
				next_cacheable = first_entry[mmu_fault_pkg::DESC_CACHEABLE];
			end
		end else if (page_invalid) begin
			// page table pointer, second entry empty or reserved
			next_fault = 1'b1;
			next_code = mmu_fault_pkg::FS_PAGE_TRANSLATION;
		end else if (domain_access == mmu_fault_pkg::DOM_NO_ACCESS ||
			domain_access == mmu_fault_pkg::DOM_RESERVED) begin
			next_fault = 1'b1;
			next_code = mmu_fault_pkg::FS_PAGE_DOMAIN;
		end else if (domain_access == mmu_fault_pkg::DOM_CLIENT &&
			!perm_ok(page_ap, sys_s, rom_r, req_user, req_write)) begin
			// manager domains skip this branch entirely
			next_fault = 1'b1;
			next_code = mmu_fault_pkg::FS_PAGE_PERMISSION;
		end else begin
			// address only formed once permissions passed
			next_phys = page_phys;
			next_bufferable = page_bufferable;
			next_cacheable = page_cacheable;
		end
	end

	// answer strobe, one cycle after the request
	// every request is answered, so the core never waits open-ended
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			resp_valid <= 1'b0;
		end else begin
			resp_valid <= req_valid;
		end
	end

	// abort flags to the core
	// prefetch aborts still reach the core, it decides whether to act
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			resp_abort <= 1'b0;
			resp_data_abort <= 1'b0;
		end else begin
			resp_abort <= req_valid && next_fault;
			resp_data_abort <= req_valid && next_fault && req_data;
		end
	end

	// external memory cycle only for clean accesses
	// the verdict is ready before the edge, so a faulting access
	// never gets as far as a memory strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mem_start <= 1'b0;
			mem_write <= 1'b0;
		end else begin
			mem_start <= req_valid && !next_fault;
			mem_write <= req_valid && !next_fault && req_write;
		end
	end

	// physical address held at zero on a fault so nothing leaks out
	// holds between requests so the memory side may sample late
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			phys_addr <= 32'h0000_0000;
		end else if (req_valid) begin
			phys_addr <= next_fault ? 32'h0000_0000 : next_phys;
		end
	end

	// cache and write buffer steering, gated by the enables
	// reads never go to the write buffer, only stores are buffered
	// illegal enable mixes are not trapped, software keeps to legal sets
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mem_bufferable <= 1'b0;
			mem_cacheable <= 1'b0;
		end else begin
			mem_bufferable <= req_valid && !next_fault && req_write && next_bufferable && wbuf_en;
			mem_cacheable <= req_valid && !next_fault && next_cacheable && cache_en;
		end
	end

	// fault status and address, data aborts only
	// last data abort wins, software never clears them
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fault_source_code <= mmu_fault_pkg::RST_FAULT_STATUS[3:0];
			fault_domain <= mmu_fault_pkg::RST_FAULT_STATUS[7:4];
			fault_address_reg <= mmu_fault_pkg::RST_FAULT_ADDRESS;
		end else if (req_valid && next_fault && req_data) begin
			// prefetch aborts may never execute, so they leave these alone
			fault_source_code <= next_code;
			fault_domain <= next_domain;
			fault_address_reg <= req_addr;
		end
	end

	// bus request decode, answered one cycle after it is raised
	// ack blocks a take in its own cycle, so a held strobe gives one transfer every second cycle
	assign bus_req = cyc_i && stb_i && !ack_o;
	assign bus_write = bus_req && we_i;

	// acknowledge, dropped the cycle after it was given
	// registered ack costs a cycle but keeps the bus path short
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= bus_req;
		end
	end

	// domain map, byte lanes honoured
	// lets software patch four domains without a read first
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_dom_lane
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					domain_permission_map[lane*8 +: 8] <= mmu_fault_pkg::RST_DOMAIN_MAP[lane*8 +: 8];
				end else if (bus_write && sel_i[lane] && adr_i == mmu_fault_pkg::OFF_DOMAIN_MAP) begin
					domain_permission_map[lane*8 +: 8] <= dat_i[lane*8 +: 8];
				end
			end
		end
	endgenerate

	// control bits live in the low byte
	// upper lanes are ignored, every field fits in byte zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			control <= {1'b0, mmu_fault_pkg::RST_CONTROL};
		end else if (bus_write && sel_i[0] && adr_i == mmu_fault_pkg::OFF_CONTROL) begin
			control <= dat_i[CTL_W-1:0];
		end
	end

	// read mux; status and address are read-only, unmapped reads zero
	// writes there are acked and dropped, the cheapest refusal
	always_comb begin
		unique case (adr_i)
			mmu_fault_pkg::OFF_DOMAIN_MAP: read_mux = domain_permission_map;
			mmu_fault_pkg::OFF_FAULT_STATUS: read_mux = {24'h00_0000, fault_domain, fault_source_code};
			mmu_fault_pkg::OFF_FAULT_ADDRESS: read_mux = fault_address_reg;
			mmu_fault_pkg::OFF_CONTROL: read_mux = {{(32-CTL_W){1'b0}}, control};
			default: read_mux = 32'h0000_0000;
		endcase
	end

	// read data registered alongside the acknowledge
	// holds the last read between cycles, a slow master still sees it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dat_o <= 32'h0000_0000;
		end else if (bus_req && !we_i) begin
			dat_o <= read_mux;
		end
	end

endmodule : mmu_fault_unit

// file: hw/mmu_fault_pkg.sv
// constants for the page translation and fault logic of the memory management unit
// assumes a 32-bit classic wishbone register port and a single processor clock
//
// What this block does
// - entry type 00 or 11 gives page translation fault
// - entry type 01 maps a 64 KB page
// - entry type 10 maps a 4 KB page
// - bit 2 routes writes through write buffer
// - bit 3 allocates page data into unified cache
// - bits 11:4 are four subpage permission fields
// - page number from 31:12 small, 31:16 large
// - check page permissions before producing physical address
// - faulting access never starts external memory cycle
// - any fault aborts access and signals core
// - data abort loads status code, domain, address
// - prefetch abort leaves status and address untouched
// - priority alignment, section then page translation
// - then section/page domain, section/page permission
// - section translation fault reports entry bits 8:5
// - sixteen two-bit domain fields, domain n at 2n
// - domain field 00 or 10 gives domain fault
// - domain field 01 checks descriptor permissions
// - domain field 11 never gives permission fault
// - subpage chosen by 1 KB or 16 KB quarter
// - permission 01 supervisor, 10 user read, 11 all
package mmu_fault_pkg;

	// register byte offsets
	localparam logic [3:0] OFF_DOMAIN_MAP = 4'h0;
	localparam logic [3:0] OFF_FAULT_STATUS = 4'h4;
	localparam logic [3:0] OFF_FAULT_ADDRESS = 4'h8;
	localparam logic [3:0] OFF_CONTROL = 4'hC;

	// reset values
	localparam logic [31:0] RST_DOMAIN_MAP = 32'h0000_0000;
	localparam logic [4:0] RST_CONTROL = 5'h00;
	localparam logic [31:0] RST_FAULT_ADDRESS = 32'h0000_0000;
	localparam logic [7:0] RST_FAULT_STATUS = 8'h00;

	// control register bit positions
	localparam int CTL_MMU_EN = 0;
	localparam int CTL_ALIGN_EN = 1;
	localparam int CTL_CACHE_EN = 2;
	localparam int CTL_WBUF_EN = 3;
	localparam int CTL_SYS_S = 4;
	localparam int CTL_ROM_R = 5;
	localparam int CTL_WIDTH = 6;

	// descriptor type codes, bits 1:0
	localparam logic [1:0] TYPE_INVALID = 2'h0;
	localparam logic [1:0] TYPE_PAGE_OR_LARGE = 2'h1;
	localparam logic [1:0] TYPE_SECTION_OR_SMALL = 2'h2;
	localparam logic [1:0] TYPE_RESERVED = 2'h3;

	// descriptor field positions
	localparam int DESC_BUFFERABLE = 2;
	localparam int DESC_CACHEABLE = 3;
	localparam int DESC_DOMAIN_LSB = 5;
	localparam int DESC_SECTION_AP_LSB = 10;
	localparam int DESC_SUBPAGE_AP_LSB = 4;
	localparam int SECTION_PAGE_LSB = 20;
	localparam int SMALL_PAGE_LSB = 12;
	localparam int LARGE_PAGE_LSB = 16;
	localparam int SMALL_SUBPAGE_LSB = 10;
	localparam int LARGE_SUBPAGE_LSB = 14;

	// domain access field values
	localparam logic [1:0] DOM_NO_ACCESS = 2'h0;
	localparam logic [1:0] DOM_CLIENT = 2'h1;
	localparam logic [1:0] DOM_RESERVED = 2'h2;
	localparam logic [1:0] DOM_MANAGER = 2'h3;

	// access permission values
	localparam logic [1:0] AP_SYSTEM = 2'h0;
	localparam logic [1:0] AP_SUPER_ONLY = 2'h1;
	localparam logic [1:0] AP_USER_READ = 2'h2;
	localparam logic [1:0] AP_ALL = 2'h3;

	// fault source codes
	localparam logic [3:0] FS_NONE = 4'h0;
	localparam logic [3:0] FS_ALIGNMENT = 4'h1;
	localparam logic [3:0] FS_SECTION_TRANSLATION = 4'h5;
	localparam logic [3:0] FS_PAGE_TRANSLATION = 4'h7;
	localparam logic [3:0] FS_SECTION_DOMAIN = 4'h9;
	localparam logic [3:0] FS_PAGE_DOMAIN = 4'hB;
	localparam logic [3:0] FS_SECTION_PERMISSION = 4'hD;
	localparam logic [3:0] FS_PAGE_PERMISSION = 4'hF;

endpackage : mmu_fault_pkg

// file: hw/page_entry_decode.sv
// decoder for a second-level page table entry
// assumes the entry and virtual address are stable in the same cycle
`timescale 1ns/100ps
module page_entry_decode (
	input wire logic [31:0] entry,
	input wire logic [31:0] virt_addr,
	output logic entry_invalid,
	output logic is_large,
	output logic bufferable,
	output logic cacheable,
	output logic [1:0] subpage_ap,
	output logic [31:0] phys_addr
);

	logic [7:0] subpage_permission_fields;
	logic [1:0] quarter;

	// size and validity from the two low bits
	always_comb begin
		entry_invalid = (entry[1:0] == mmu_fault_pkg::TYPE_INVALID) ||
			(entry[1:0] == mmu_fault_pkg::TYPE_RESERVED);
		is_large = (entry[1:0] == mmu_fault_pkg::TYPE_PAGE_OR_LARGE);
	end

	// cache and buffer attributes
	assign bufferable = entry[mmu_fault_pkg::DESC_BUFFERABLE];
	assign cacheable = entry[mmu_fault_pkg::DESC_CACHEABLE];

	// four two-bit fields, the top one covers the top quarter
	assign subpage_permission_fields = entry[mmu_fault_pkg::DESC_SUBPAGE_AP_LSB +: 8];
	assign quarter = is_large ? virt_addr[mmu_fault_pkg::LARGE_SUBPAGE_LSB +: 2]
		: virt_addr[mmu_fault_pkg::SMALL_SUBPAGE_LSB +: 2];
	assign subpage_ap = subpage_permission_fields[{quarter, 1'b0} +: 2];

	// bits 15:12 of a large entry are ignored, software keeps them zero
	always_comb begin
		if (is_large) begin
			phys_addr = {entry[31:mmu_fault_pkg::LARGE_PAGE_LSB],
				virt_addr[mmu_fault_pkg::LARGE_PAGE_LSB-1:0]};
		end else begin
			phys_addr = {entry[31:mmu_fault_pkg::SMALL_PAGE_LSB],
				virt_addr[mmu_fault_pkg::SMALL_PAGE_LSB-1:0]};
		end
	end

endmodule : page_entry_decode

// file: test/mmu_fault_unit_properties.sv
// concurrent checks on the ports of the translation and fault unit
// assumes one clock and the asynchronous active-high reset of the unit
`timescale 1ns/100ps
module mmu_fault_checker (
	input wire logic clk,
	input wire logic reset,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic req_valid,
	input wire logic [31:0] req_addr,
	input wire logic req_data,
	input wire logic [31:0] first_entry,
	input wire logic [31:0] second_entry,
	input wire logic resp_valid,
	input wire logic resp_abort,
	input wire logic resp_data_abort,
	input wire logic [31:0] phys_addr,
	input wire logic mem_start,
	input wire logic mem_write,
	input wire logic mem_bufferable,
	input wire logic mem_cacheable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// a flat answer (mmu off) is accepted wherever a translation is expected
	a_resp_follows_req: assert property (req_valid |=> resp_valid)
		else $error("no answer one cycle after request");
	a_abort_no_mem: assert property (resp_abort |-> !mem_start && !mem_write)
		else $error("memory cycle started on an aborted access");
	a_abort_or_start: assert property (resp_valid |-> (resp_abort ^ mem_start))
		else $error("answer neither aborted nor started memory");
	a_prefetch_quiet: assert property (req_valid && !req_data |=> !resp_data_abort)
		else $error("prefetch reported as data abort");
	a_small_page_number: assert property (req_valid && first_entry[1:0] == 2'b01 && second_entry[1:0] == 2'b10
		|=> resp_abort || phys_addr == $past(req_addr)
		|| phys_addr == (($past(second_entry) & 32'hFFFF_F000) | ($past(req_addr) & 32'h0000_0FFF)))
		else $error("small page address wrong");
	a_large_page_number: assert property (req_valid && first_entry[1:0] == 2'b01 && second_entry[1:0] == 2'b01
		|=> resp_abort || phys_addr == $past(req_addr)
		|| phys_addr == (($past(second_entry) & 32'hFFFF_0000) | ($past(req_addr) & 32'h0000_FFFF)))
		else $error("large page address wrong");
	a_bad_entry_aborts: assert property (req_valid && first_entry[1:0] == 2'b01 && second_entry[1:0] inside {2'b00, 2'b11}
		|=> resp_abort || phys_addr == $past(req_addr))
		else $error("invalid page entry translated");
	a_buffer_writes_only: assert property (mem_bufferable |-> mem_start && mem_write)
		else $error("bufferable flag without a write");
	a_cache_needs_start: assert property (mem_cacheable |-> mem_start)
		else $error("cacheable flag without memory cycle");
	a_bus_ack_pulse: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("register ack not a single cycle pulse");
endmodule : mmu_fault_checker

bind mmu_fault_unit mmu_fault_checker mmu_fault_checker_i (.clk(clk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i),
	.ack_o(ack_o), .req_valid(req_valid), .req_addr(req_addr), .req_data(req_data), .first_entry(first_entry),
	.second_entry(second_entry), .resp_valid(resp_valid), .resp_abort(resp_abort), .resp_data_abort(resp_data_abort),
	.phys_addr(phys_addr), .mem_start(mem_start), .mem_write(mem_write), .mem_bufferable(mem_bufferable),
	.mem_cacheable(mem_cacheable));

// file: test/core_model.sv
// model of the processor core issuing translation requests with fetched entries
// assumes the bench calls access from one process, one request at a time
`timescale 1ns/100ps
module core_model (
	input wire logic clk,
	output logic req_valid,
	output logic [31:0] req_addr,
	output logic req_write,
	output logic req_word,
	output logic req_user,
	output logic req_data,
	output logic [31:0] first_entry,
	output logic [31:0] second_entry
);
	// idle lines until the first request
	initial begin
		req_valid = 1'b0;
		{req_write, req_word, req_user, req_data} = 4'h0;
		req_addr = 32'h0000_0000;
		first_entry = 32'h0000_0000;
		second_entry = 32'h0000_0000;
	end

	// flags are write, word, user, data; returns in the answer cycle
	task automatic access(input logic [31:0] a, input logic [3:0] f, input logic [31:0] e1, input logic [31:0] e2);
		logic [31:0] e2_clean;
		e2_clean = (e2[1:0] == 2'b01) ? (e2 & 32'hFFFF_0FFF) : e2; // large entries keep 15:12 zero
		@(posedge clk);
		req_valid <= 1'b1;
		req_addr <= a;
		{req_write, req_word, req_user, req_data} <= f;
		first_entry <= e1;
		second_entry <= e2_clean; // one entry stands for all 16 replicated slots
		@(posedge clk);
		// released lines carry junk so stale values cannot pass
		req_valid <= 1'b0;
		req_addr <= ~a;
		{req_write, req_word, req_user, req_data} <= ~f;
		first_entry <= ~e1;
		second_entry <= ~e2_clean;
		@(negedge clk);
	endtask : access
endmodule : core_model

// file: test/test_mmu_fault_unit.sv
// self-checking bench for the translation and fault unit
// assumes the core model drives requests and this bench is the wishbone master
`timescale 1ns/100ps
module test_mmu_fault_unit;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [3:0] adr_i = 4'h0;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [31:0] dat_o, req_addr, first_entry, second_entry, phys_addr;
	logic ack_o, req_valid, req_write, req_word, req_user, req_data;
	logic resp_valid, resp_abort, resp_data_abort, mem_start, mem_write, mem_bufferable, mem_cacheable;
	logic [7:0] exp_fs = 8'h00;
	logic [31:0] exp_far = 32'h0000_0000;
	int err_total = 0;
	int n_tests = 0;

	always #4 clk = ~clk;

	mmu_fault_unit mmu_fault_unit_i (.clk(clk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .req_valid(req_valid),
		.req_addr(req_addr), .req_write(req_write), .req_word(req_word), .req_user(req_user), .req_data(req_data),
		.first_entry(first_entry), .second_entry(second_entry), .resp_valid(resp_valid), .resp_abort(resp_abort),
		.resp_data_abort(resp_data_abort), .phys_addr(phys_addr), .mem_start(mem_start), .mem_write(mem_write),
		.mem_bufferable(mem_bufferable), .mem_cacheable(mem_cacheable));

	core_model core_model_i (.clk(clk), .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
		.req_word(req_word), .req_user(req_user), .req_data(req_data), .first_entry(first_entry),
		.second_entry(second_entry));

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one classic cycle; the wait is bounded so a dead slave ends the run
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clk);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, we, adr, wd};
		for (n = 0; n < 20 && ack_o !== 1'b1; n++) @(posedge clk);
		if (ack_o !== 1'b1) begin
			err_total++;
			wrap_up();
		end
		rd = dat_o;
		{cyc_i, stb_i} <= 2'b00;
	endtask : wb

	task automatic wr(input logic [3:0] adr, input logic [31:0] d);
		logic [31:0] unused;
		wb(1'b1, adr, d, unused);
	endtask : wr

	task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
		logic [31:0] v;
		wb(1'b0, adr, 32'h0000_0000, v);
		check(v, exp);
	endtask : rd

	// code 0 means the access must pass; status and address follow data aborts only
	task automatic run(input logic [31:0] a, input logic [3:0] f, input logic [31:0] e1, input logic [31:0] e2,
		input logic [3:0] code, input logic [3:0] dom, input logic [31:0] ph, input logic [1:0] bc);
		logic ab;
		ab = (code != 4'h0);
		core_model_i.access(a, f, e1, e2);
		check(32'({resp_valid, resp_abort, resp_data_abort, mem_start, mem_write}), 32'({1'b1, ab, ab & f[0], !ab, !ab & f[3]}));
		check(phys_addr, ab ? 32'h0000_0000 : ph);
		check(32'({mem_bufferable, mem_cacheable}), 32'(bc));
		if (ab && f[0]) begin
			exp_fs = {dom, code};
			exp_far = a;
		end
		rd(4'h4, {24'h00_0000, exp_fs});
		rd(4'h8, exp_far);
	endtask : run

	// main sequence: registers, flat access, then the fault table
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd(4'h0, 32'h0000_0000);
		rd(4'hC, 32'h0000_0000);
		wr(4'h4, 32'hFFFF_FFFF);
		rd(4'h4, 32'h0000_0000);
		rd(4'h2, 32'h0000_0000);
		run(32'h1234_5678, 4'b0101, 32'h0000_0071, 32'h0000_0000, 4'h0, 4'h0, 32'h1234_5678, 2'b00);
		wr(4'hC, 32'h0000_000F);
		rd(4'hC, 32'h0000_000F);
		wr(4'h0, 32'h0008_0C40);
		rd(4'h0, 32'h0008_0C40);
		sel_i <= 4'h2;
		wr(4'h0, 32'hFFFF_FFFF);
		sel_i <= 4'hF;
		rd(4'h0, 32'h0008_FF40);
		wr(4'h0, 32'h0008_0C40);
		run(32'h0000_0AB8, 4'b1101, 32'h0000_0071, 32'h1234_5FFE, 4'h0, 4'h0, 32'h1234_5AB8, 2'b11);
		run(32'h0000_0AB8, 4'b0101, 32'h0000_0071, 32'h1234_5FFE, 4'h0, 4'h0, 32'h1234_5AB8, 2'b01);
		run(32'h0003_7654, 4'b0101, 32'h0000_0071, 32'hABCD_0FF1, 4'h0, 4'h0, 32'hABCD_7654, 2'b00);
		run(32'h0000_0100, 4'b0111, 32'h0000_0071, 32'h0000_1FD2, 4'hF, 4'h3, 32'h0, 2'b00);
		run(32'h0000_0D00, 4'b0111, 32'h0000_0071, 32'h0000_1FD2, 4'h0, 4'h0, 32'h0000_1D00, 2'b00);
		run(32'h0000_0100, 4'b1101, 32'h0000_0071, 32'h0000_1FD2, 4'h0, 4'h0, 32'h0000_1100, 2'b00);
		run(32'h0000_C010, 4'b0111, 32'h0000_0071, 32'h0005_0FD1, 4'h0, 4'h0, 32'h0005_C010, 2'b00);
		run(32'h0000_0010, 4'b0111, 32'h0000_0071, 32'h0005_0FD1, 4'hF, 4'h3, 32'h0, 2'b00);
		run(32'h0000_0040, 4'b1111, 32'h0000_0071, 32'h0000_2AA2, 4'hF, 4'h3, 32'h0, 2'b00);
		run(32'h0000_0040, 4'b0111, 32'h0000_0071, 32'h0000_2AA2, 4'h0, 4'h0, 32'h0000_2040, 2'b00);
		run(32'h0000_0040, 4'b1111, 32'h0000_00B1, 32'h0000_3552, 4'h0, 4'h0, 32'h0000_3040, 2'b00);
		run(32'h0000_0040, 4'b0101, 32'h0000_00F1, 32'h0000_3FF2, 4'hB, 4'h7, 32'h0, 2'b00);
		run(32'h0000_0040, 4'b0101, 32'h0000_0131, 32'h0000_3FF2, 4'hB, 4'h9, 32'h0, 2'b00);
		run(32'h0000_0040, 4'b0101, 32'h0000_00F1, 32'h0000_3FF0, 4'h7, 4'h7, 32'h0, 2'b00);
		run(32'h0000_0040, 4'b0101, 32'h0000_0071, 32'h0000_3FF3, 4'h7, 4'h3, 32'h0, 2'b00);
		run(32'h0000_0040, 4'b0101, 32'h0000_0180, 32'h0000_3FF2, 4'h5, 4'hC, 32'h0, 2'b00);
		run(32'h0000_0040, 4'b0101, 32'h0000_0183, 32'h0000_3FF2, 4'h5, 4'hC, 32'h0, 2'b00);
		run(32'h0000_0042, 4'b0101, 32'h0000_0180, 32'h0000_0000, 4'h1, 4'h0, 32'h0, 2'b00);
		run(32'h0000_0041, 4'b0001, 32'h0000_0071, 32'h0000_3FF2, 4'h0, 4'h0, 32'h0000_3041, 2'b00);
		run(32'h0000_0040, 4'b0101, 32'h0010_00F2, 32'h0000_0000, 4'h9, 4'h7, 32'h0, 2'b00);
		run(32'h0000_0040, 4'b0111, 32'h0020_0472, 32'h0000_0000, 4'hD, 4'h3, 32'h0, 2'b00);
		run(32'h0000_0044, 4'b0100, 32'h0000_0071, 32'h0000_3FF0, 4'h7, 4'h3, 32'h0, 2'b00);
		wr(4'hC, 32'h0000_001F);
		run(32'h0000_0040, 4'b0101, 32'h0000_0071, 32'h0000_3002, 4'h0, 4'h0, 32'h0000_3040, 2'b00);
		run(32'h0000_0040, 4'b1101, 32'h0000_0071, 32'h0000_3002, 4'hF, 4'h3, 32'h0, 2'b00);
		wr(4'hC, 32'h0000_002F);
		run(32'h0000_0040, 4'b0111, 32'h0000_0071, 32'h0000_3002, 4'h0, 4'h0, 32'h0000_3040, 2'b00);
		wr(4'hC, 32'h0000_0003);
		run(32'h0000_0040, 4'b1101, 32'h0000_0071, 32'h0000_3FFE, 4'h0, 4'h0, 32'h0000_3040, 2'b00);
		wrap_up();
	end
endmodule : test_mmu_fault_unit
